// File: hdl/aic_pkg.sv
// Operation
// - frequency-reference inputs use second-order low-pass, others first-order, time settable.
// - range code 0: zero to full scale maps linearly to 0..100 percent.
// - range code 1: twenty percent of full scale is zero, top is 100 percent.
// - range code 2: negative to positive full scale maps to -100..+100 percent.
// - range code 3: custom low/high levels within -160..160 percent give min..max.
// - per-input reference scaling min/max maps onto its own reference span.
// - nonzero dead zone forces a reference of smaller magnitude to exactly zero.
// - sleep stop when input below limit, or within plus/minus limit in joystick mode.
// - sleep only after condition held for the sleep delay; any exit restarts timing.
// - capture stores present level as zero offset; clear sets offset to zero.
// - inputs three and four take their raw value from a fieldbus word when selected.
// - inputs three and four each have a first-order filter with own time.
// - inputs three and four scale between custom levels bounded to -160..160 percent.
// - invert setting 1 on input three or four turns zero input into maximum output.
// - inputs three and four map linearly to integer target min/max for a target id.
// - inversion mask: each set bit except bits 6 and 7 inverts one digital input function.
// - every digital output function is off after reset until enabled.
// - ready, run, fault, warning and inverted fault outputs; inverted only with no fault.
// - reverse output while output frequency is below zero.
// - wrong-direction output while rotation sign differs from requested direction.
// - at-reference: within nominal slip (induction) or within 1 Hz (permanent magnet).
// - external fault and reference loss drive fault or warning per chosen response.
package aic_pkg;
  typedef logic signed [31:0] val_t;
  typedef logic [4:0] addr_t;
  typedef logic [1:0] resp_t;

  localparam int CLK_NS = 10;
  localparam int SAMPLE_NS = 1000;
  localparam int SAMPLE_CYC = (SAMPLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int MS_NS = 1000000;
  localparam int MS_SAMPLES = MS_NS / SAMPLE_NS;

  localparam val_t FULL = 32'sd10000;
  localparam val_t LIVE_ZERO = 32'sd2000;
  localparam val_t CUST_LIM = 32'sd16000;
  localparam val_t PM_BAND = 32'sd100;
  localparam val_t LOSS_LIM = 32'sd1000;
  localparam logic [15:0] CUST_LOW_RST = 16'h0000;
  localparam logic [15:0] CUST_HIGH_RST = 16'h2710;

  localparam resp_t RESP_NONE = 2'h0;
  localparam resp_t RESP_WARN = 2'h1;
  localparam resp_t RESP_FAULT = 2'h3;

  localparam int CFG_WORDS = 18;
  localparam addr_t A_CTRL = 5'h00;
  localparam addr_t A_FILT = 5'h01;
  localparam addr_t A_CUST1 = 5'h02;
  localparam addr_t A_CUST4 = 5'h05;
  localparam addr_t A_REFSC1 = 5'h06;
  localparam addr_t A_DEAD = 5'h08;
  localparam addr_t A_SLEEP = 5'h09;
  localparam addr_t A_FBUS = 5'h0a;
  localparam addr_t A_TSC3 = 5'h0b;
  localparam addr_t A_TID = 5'h0d;
  localparam addr_t A_INVMASK = 5'h0e;
  localparam addr_t A_DOEN = 5'h0f;
  localparam addr_t A_CMD = 5'h12;
  localparam addr_t A_OFFSET = 5'h13;
  localparam addr_t A_REFS = 5'h14;
  localparam addr_t A_TVAL = 5'h15;
  localparam addr_t A_STAT = 5'h16;

  localparam int F_RANGE = 0;
  localparam int F_FREQREF = 4;
  localparam int F_JOY = 6;
  localparam int F_SRC3 = 7;
  localparam int F_INV3 = 9;
  localparam int F_PM = 11;
  localparam int F_EXTRESP = 12;
  localparam int F_LOSSRESP = 14;
  localparam int C_CAPTURE = 0;
  localparam int C_CLEAR = 1;
  localparam logic [9:0] INV_MASK_VALID = 10'h33f;

  localparam int S_READY = 0;
  localparam int S_RUN = 1;
  localparam int S_FAULT = 2;
  localparam int S_FAULTN = 3;
  localparam int S_WARN = 4;
  localparam int S_EXT = 5;
  localparam int S_LOSS = 6;
  localparam int S_TEMP = 7;
  localparam int S_REV = 8;
  localparam int S_WRONG = 9;
  localparam int S_ATREF = 10;
  localparam int S_SLEEP = 11;
  localparam int ST_W = 12;
endpackage : aic_pkg

// File: hdl/analog_input_conditioning.sv
`timescale 1ns/1ns
module analog_input_conditioning
  import aic_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [4:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic [3:0][15:0] termIn,
  input wire logic [9:0] diPin,
  input wire logic driveReady,
  input wire logic driveRun,
  input wire logic driveFault,
  input wire logic driveWarn,
  input wire logic extFault,
  input wire logic overTemp,
  input wire logic signed [15:0] outFreq,
  input wire logic signed [15:0] freqRef,
  input wire logic signed [15:0] motorSpeed,
  input wire logic [15:0] nomSlip,
  input wire logic dirReverse,
  output logic [1:0][15:0] refOut,
  output logic [1:0][15:0] targetValue,
  output logic [1:0][15:0] targetParameter,
  output logic [9:0] diFunc,
  output logic [ST_W-1:0] statusOut
);
  function automatic val_t sat(input val_t v, input val_t lo, input val_t hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : sat

  // linear map of [lo,hi] onto [oLo,oHi]; an empty input span yields oLo
  function automatic val_t span(input val_t v, input val_t lo, input val_t hi,
                                input val_t oLo, input val_t oHi);
    val_t d;
    d = hi - lo;
    if (d == 0) return oLo;
    return oLo + ((v - lo) * (oHi - oLo)) / d;
  endfunction : span

  function automatic val_t sx(input logic [15:0] h);
    return val_t'(signed'(h));
  endfunction : sx

  function automatic val_t absv(input val_t v);
    return (v < 0) ? -v : v;
  endfunction : absv

  logic [31:0] cfg_q [CFG_WORDS];
  logic [31:0] rdata_q;
  logic [15:0] offset_q;
  logic [1:0][15:0] refOut_q;
  logic [1:0][15:0] tgtVal_q;
  logic [ST_W-1:0] stat_q;
  logic [9:0] diMeta_q;
  logic [9:0] diSync_q;
  logic [9:0] diFunc_q;
  logic [6:0] smpCnt_q;
  logic [9:0] msCnt_q;
  logic smpTick;
  logic msTick;

  // ---------------- register port ----------------
  wire cfgHit = addr < addr_t'(CFG_WORDS);
  wire cmdWr = wr && addr == A_CMD;
  wire [31:0] ctrl = cfg_q[A_CTRL];
  wire [31:0] filt = cfg_q[A_FILT];
  wire [31:0] invMask = cfg_q[A_INVMASK];
  wire [31:0] doEn = cfg_q[A_DOEN];
  wire sleepFlag;
  wire [31:0] rdMux = cfgHit ? cfg_q[addr] :
                      (addr == A_OFFSET) ? {16'h0000, offset_q} :
                      (addr == A_REFS) ? {refOut_q[1], refOut_q[0]} :
                      (addr == A_TVAL) ? {tgtVal_q[1], tgtVal_q[0]} :
                      (addr == A_STAT) ? {20'h00000, stat_q} : 32'h0000_0000;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < CFG_WORDS; i++) begin
        cfg_q[i] <= (i >= int'(A_CUST1) && i <= int'(A_CUST4)) ?
                    {CUST_HIGH_RST, CUST_LOW_RST} : 32'h0000_0000;
      end
    end else if (wr && cfgHit) begin
      cfg_q[addr] <= wdata;
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clock or posedge rst) begin
    if (rst) rdata_q <= '0;
    else rdata_q <= rd ? rdMux : 32'h0000_0000;
  end
  assign rdata = rdata_q;

  // ---------------- sample and millisecond ticks ----------------
  assign smpTick = smpCnt_q == 7'(SAMPLE_CYC - 1);
  assign msTick = smpTick && msCnt_q == 10'(MS_SAMPLES - 1);
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      smpCnt_q <= '0;
      msCnt_q <= '0;
    end else begin
      smpCnt_q <= smpTick ? '0 : smpCnt_q + 7'h01;
      if (smpTick) msCnt_q <= msTick ? '0 : msCnt_q + 10'h001;
    end
  end

  a_ms_tick: assert property (@(posedge clock) disable iff (rst)
    msTick |-> smpTick)
    else $error("millisecond tick off the sample grid");

  // ---------------- inputs one and two ----------------
  val_t pct [2];
  val_t centred [2];
  val_t zoned [2];

  for (genvar i = 0; i < 2; i++) begin : g_ref
    val_t fa;
    val_t fb;
    val_t filtV;
    val_t custLo;
    val_t custHi;
    val_t scaled;
    val_t clipped;
    wire [1:0] rangeCode = ctrl[F_RANGE + 2 * i +: 2];
    wire [31:0] cust = cfg_q[int'(A_CUST1) + i];
    wire [31:0] refSc = cfg_q[int'(A_REFSC1) + i];
    wire [15:0] deadZone = cfg_q[A_DEAD][16 * i +: 16];
    wire [3:0] fShift = filt[4 * i +: 4];

    lp_stage u_first (
      .clock(clock),
      .rst(rst),
      .tick(smpTick),
      .shift(fShift),
      .x(sx(termIn[i])),
      .y(fa)
    );
    lp_stage u_second (
      .clock(clock),
      .rst(rst),
      .tick(smpTick),
      .shift(fShift),
      .x(fa),
      .y(fb)
    );
    assign filtV = ctrl[F_FREQREF + i] ? fb : fa;
    assign custLo = sat(sx(cust[15:0]), -CUST_LIM, CUST_LIM);
    assign custHi = sat(sx(cust[31:16]), -CUST_LIM, CUST_LIM);

    always_comb begin
      unique case (rangeCode)
        2'h0: pct[i] = sat(filtV, 0, FULL);
        2'h1: pct[i] = sat(span(filtV, LIVE_ZERO, FULL, 0, FULL), 0, FULL);
        2'h2: pct[i] = sat(filtV, -FULL, FULL);
        2'h3: pct[i] = sat(span(filtV, custLo, custHi, 0, FULL), 0, FULL);
      endcase
    end

    // equal scaling limits mean the reference span is left as it is
    assign scaled = (refSc[15:0] == refSc[31:16]) ? pct[i] :
                    span(pct[i], 0, FULL, sx(refSc[15:0]), sx(refSc[31:16]));
    assign centred[i] = (i == 1) ? scaled - sx(offset_q) : scaled;
    assign zoned[i] = (deadZone != 16'h0000 && absv(centred[i]) < sx(deadZone)) ?
                      32'sd0 : centred[i];
    // offset and scaling together can leave the 16-bit range; clip instead of wrapping
    assign clipped = sat(zoned[i], -CUST_LIM, CUST_LIM);

    always_ff @(posedge clock or posedge rst) begin
      if (rst) refOut_q[i] <= '0;
      else refOut_q[i] <= clipped[15:0];
    end
  end
  assign refOut = refOut_q;

  wire [15:0] deadZoneOne = cfg_q[A_DEAD][15:0];
  wire [15:0] refOne = refOut_q[0];
  a_dead_zone: assert property (@(posedge clock) disable iff (rst)
    refOne != 16'h0000 && $past(deadZoneOne) != 16'h0000
    |-> absv(sx(refOne)) >= sx($past(deadZoneOne)))
    else $error("reference inside dead zone not forced to zero");
  a_ref_bounds: assert property (@(posedge clock) disable iff (rst)
    absv(sx(refOut_q[0])) <= CUST_LIM)
    else $error("reference outside saturation bounds");

  // zero offset for input two: clear wins over a capture in the same write
  always_ff @(posedge clock or posedge rst) begin
    if (rst) offset_q <= '0;
    else if (cmdWr && wdata[C_CLEAR]) offset_q <= '0;
    else if (cmdWr && wdata[C_CAPTURE]) offset_q <= pct[1][15:0];
  end
  a_offset_clear: assert property (@(posedge clock) disable iff (rst)
    cmdWr && wdata[C_CLEAR] |=> offset_q == 16'h0000 ##1 offset_q == 16'h0000 || $past(cmdWr))
    else $error("offset not cleared");
  wire [15:0] levelTwo = pct[1][15:0];
  a_capture_level: assert property (@(posedge clock) disable iff (rst)
    cmdWr && wdata[C_CAPTURE] && !wdata[C_CLEAR] |=> offset_q == $past(levelTwo))
    else $error("captured offset differs from input level");
  a_clear_wins: assert property (@(posedge clock) disable iff (rst)
    cmdWr && wdata[C_CAPTURE] && wdata[C_CLEAR] |=> offset_q == 16'h0000)
    else $error("capture overrode clear");

  // ---------------- sleep on input two ----------------
  wire signed [15:0] sleepLim = cfg_q[A_SLEEP][15:0];
  wire sleepCond = ctrl[F_JOY] ? (absv(centred[1]) < sx(sleepLim)) :
                                 (centred[1] < sx(sleepLim));
  sleep_timer u_sleep (
    .clock(clock),
    .rst(rst),
    .msTick(msTick),
    .cond(sleepCond),
    .delayMs(cfg_q[A_SLEEP][31:16]),
    .sleep(sleepFlag)
  );

  // ---------------- inputs three and four ----------------
  for (genvar j = 0; j < 2; j++) begin : g_any
    val_t raw;
    val_t f;
    val_t lvl;
    val_t inv;
    val_t tgt;
    wire [31:0] cust = cfg_q[int'(A_CUST1) + 2 + j];
    wire [31:0] tsc = cfg_q[int'(A_TSC3) + j];
    assign raw = ctrl[F_SRC3 + j] ? sx(cfg_q[A_FBUS][16 * j +: 16]) : sx(termIn[2 + j]);
    lp_stage u_filt (
      .clock(clock),
      .rst(rst),
      .tick(smpTick),
      .shift(filt[8 + 4 * j +: 4]),
      .x(raw),
      .y(f)
    );
    assign lvl = sat(span(f, sat(sx(cust[15:0]), -CUST_LIM, CUST_LIM),
                          sat(sx(cust[31:16]), -CUST_LIM, CUST_LIM), 0, FULL), 0, FULL);
    assign inv = ctrl[F_INV3 + j] ? FULL - lvl : lvl;
    assign tgt = span(inv, 0, FULL, sx(tsc[15:0]), sx(tsc[31:16]));
    always_ff @(posedge clock or posedge rst) begin
      if (rst) tgtVal_q[j] <= '0;
      else tgtVal_q[j] <= tgt[15:0];
    end
    assign targetParameter[j] = cfg_q[A_TID][16 * j +: 16];
  end
  assign targetValue = tgtVal_q;

  // ---------------- digital input inversion ----------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      diMeta_q <= '0;
      diSync_q <= '0;
      diFunc_q <= '0;
    end else begin
      diMeta_q <= diPin;
      diSync_q <= diMeta_q;
      diFunc_q <= diSync_q ^ (invMask[9:0] & INV_MASK_VALID);
    end
  end
  assign diFunc = diFunc_q;
  a_inv_mask: assert property (@(posedge clock) disable iff (rst)
    $past(invMask[9:0]) == 10'h000 |-> diFunc_q == $past(diSync_q))
    else $error("function inverted with clear mask");

  // ---------------- status outputs ----------------
  wire resp_t extResp = ctrl[F_EXTRESP +: 2];
  wire resp_t lossResp = ctrl[F_LOSSRESP +: 2];
  // loss is only meaningful on the live-zero range of input one
  wire refLoss = ctrl[F_RANGE +: 2] == 2'h1 && sx(termIn[0]) < LOSS_LIM;
  // the unused response code behaves like no response, so it shows nothing
  wire extInd = extFault && (extResp == RESP_WARN || extResp == RESP_FAULT);
  wire lossInd = refLoss && (lossResp == RESP_WARN || lossResp == RESP_FAULT);
  wire anyFault = driveFault || (extFault && extResp == RESP_FAULT)
                  || (refLoss && lossResp == RESP_FAULT);
  wire anyWarn = driveWarn || (extFault && extResp == RESP_WARN)
                 || (refLoss && lossResp == RESP_WARN);
  wire wrongDir = motorSpeed != 0 && (motorSpeed < 0) != dirReverse;
  wire [16:0] spdErr = 17'(absv(sx(motorSpeed) - sx(freqRef)));
  wire [16:0] frqErr = 17'(absv(sx(outFreq) - sx(freqRef)));
  wire atRef = ctrl[F_PM] ? (frqErr <= 17'(PM_BAND)) : (spdErr <= {1'b0, nomSlip});

  logic [ST_W-1:0] statRaw;
  always_comb begin
    statRaw = '0;
    statRaw[S_READY] = driveReady;
    statRaw[S_RUN] = driveRun;
    statRaw[S_FAULT] = anyFault;
    statRaw[S_FAULTN] = !anyFault;
    statRaw[S_WARN] = anyWarn;
    statRaw[S_EXT] = extInd;
    statRaw[S_LOSS] = lossInd;
    statRaw[S_TEMP] = overTemp;
    statRaw[S_REV] = outFreq < 0;
    statRaw[S_WRONG] = wrongDir;
    statRaw[S_ATREF] = atRef;
    statRaw[S_SLEEP] = sleepFlag;
  end

  // a function reaches its output only once software has mapped it
  always_ff @(posedge clock or posedge rst) begin
    if (rst) stat_q <= '0;
    else stat_q <= statRaw & doEn[ST_W-1:0];
  end
  assign statusOut = stat_q;

  a_do_default: assert property (@(posedge clock) disable iff (rst)
    doEn[ST_W-1:0] == '0 |=> stat_q == '0)
    else $error("unmapped output active");
  a_fault_pair: assert property (@(posedge clock) disable iff (rst)
    !(stat_q[S_FAULT] && stat_q[S_FAULTN]))
    else $error("fault and inverted fault both active");
  a_reverse_out: assert property (@(posedge clock) disable iff (rst)
    outFreq < 0 && doEn[S_REV] |=> stat_q[S_REV])
    else $error("reverse not shown for negative frequency");
  a_read_once: assert property (@(posedge clock) disable iff (rst)
    rdata_q != 32'h0000_0000 |-> $past(rd))
    else $error("read data outside read slot");

  a_ready_shown: assert property (@(posedge clock) disable iff (rst)
    driveReady && doEn[S_READY] |=> stat_q[S_READY])
    else $error("ready not shown");
  a_fault_inverted: assert property (@(posedge clock) disable iff (rst)
    anyFault |=> !stat_q[S_FAULTN])
    else $error("inverted fault active during a fault");
  a_fault_shown: assert property (@(posedge clock) disable iff (rst)
    anyFault && doEn[S_FAULT] |=> stat_q[S_FAULT])
    else $error("fault not shown");
  a_wrong_dir: assert property (@(posedge clock) disable iff (rst)
    motorSpeed < 0 && !dirReverse && doEn[S_WRONG] |=> stat_q[S_WRONG])
    else $error("wrong direction not shown");
  a_pm_outside: assert property (@(posedge clock) disable iff (rst)
    ctrl[F_PM] && absv(sx(outFreq) - sx(freqRef)) > PM_BAND |=> !stat_q[S_ATREF])
    else $error("at reference shown outside band");
  a_ext_warning: assert property (@(posedge clock) disable iff (rst)
    extFault && extResp == RESP_WARN && doEn[S_WARN] |=> stat_q[S_WARN])
    else $error("external warning not shown");
  a_ext_silent: assert property (@(posedge clock) disable iff (rst)
    !extResp[0] |=> !stat_q[S_EXT])
    else $error("external indication without response");
  a_loss_shown: assert property (@(posedge clock) disable iff (rst)
    refLoss && lossResp == RESP_WARN && doEn[S_LOSS] |=> stat_q[S_LOSS])
    else $error("reference loss not shown");
  a_reverse_clear: assert property (@(posedge clock) disable iff (rst)
    outFreq >= 0 |=> !stat_q[S_REV])
    else $error("reverse shown for positive frequency");
  a_sleep_shown: assert property (@(posedge clock) disable iff (rst)
    sleepFlag && doEn[S_SLEEP] |=> stat_q[S_SLEEP])
    else $error("sleep not shown");
endmodule : analog_input_conditioning

// File: hdl/lp_stage.sv
`timescale 1ns/1ns
module lp_stage
  import aic_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic tick,
  input wire logic [3:0] shift,
  input wire val_t x,
  output val_t y
);
  val_t y_q;
  val_t y_d;
  // arithmetic shift keeps the sign, so a falling input settles from above too
  assign y_d = y_q + ((x - y_q) >>> shift);
  assign y = y_q;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) y_q <= '0;
    else if (tick) y_q <= y_d;
  end
endmodule : lp_stage

// File: hdl/sleep_timer.sv
`timescale 1ns/1ns
module sleep_timer
  import aic_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic msTick,
  input wire logic cond,
  input wire logic [15:0] delayMs,
  output logic sleep
);
  logic [15:0] cnt_q;
  logic sleep_q;
  assign sleep = sleep_q;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      sleep_q <= 1'b0;
    end else begin
      cnt_q <= !cond ? '0 : ((msTick && cnt_q != delayMs) ? cnt_q + 16'h0001 : cnt_q);
      sleep_q <= cond && cnt_q == delayMs;
    end
  end

  a_sleep_exit: assert property (@(posedge clock) disable iff (rst) !cond |=> !sleep_q)
    else $error("sleep held after condition left");
  a_sleep_held: assert property (@(posedge clock) disable iff (rst)
    $rose(sleep_q) |-> $past(cond) && $past(cnt_q) == $past(delayMs))
    else $error("sleep before delay expired");
endmodule : sleep_timer

// File: sim/analog_input_conditioning_bench.sv
`timescale 1ns/1ns
module analog_input_conditioning_bench;
  import aic_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [4:0] addr = '0;
  logic [31:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [3:0][15:0] termIn;
  logic [9:0] diPin = '0;
  logic driveReady = 1'b1;
  logic driveRun = 1'b1;
  logic driveFault = 1'b0;
  logic driveWarn = 1'b0;
  logic extFault = 1'b0;
  logic overTemp = 1'b0;
  logic signed [15:0] outFreq = 16'h03e8;
  logic signed [15:0] freqRef = 16'h03e8;
  logic signed [15:0] motorSpeed = 16'h03e8;
  logic [15:0] nomSlip = 16'h0032;
  logic dirReverse = 1'b0;
  logic [1:0][15:0] refOut;
  logic [1:0][15:0] targetValue;
  logic [1:0][15:0] targetParameter;
  logic [9:0] diFunc;
  logic [ST_W-1:0] statusOut;
  logic [31:0] rv;
  int nErrors = 0;
  int nChecks = 0;

  analog_source_model src (.termLevel(termIn), .clock(clock));

  analog_input_conditioning dut (
    .clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .termIn(termIn), .diPin(diPin), .driveReady(driveReady), .driveRun(driveRun),
    .driveFault(driveFault), .driveWarn(driveWarn), .extFault(extFault), .overTemp(overTemp),
    .outFreq(outFreq), .freqRef(freqRef), .motorSpeed(motorSpeed), .nomSlip(nomSlip),
    .dirReverse(dirReverse), .refOut(refOut), .targetValue(targetValue),
    .targetParameter(targetParameter), .diFunc(diFunc), .statusOut(statusOut)
  );

  always #5 clock = ~clock;

  task automatic endSim;
    $display("checks %0d errors %0d", nChecks, nErrors);
    if (nErrors == 0 && nChecks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : endSim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    nChecks++;
    if (got !== exp) begin
      nErrors++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic waitCyc(input int n);
    repeat (n) @(posedge clock);
  endtask : waitCyc

  task automatic wrReg(input logic [4:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wrReg

  task automatic rdReg(input logic [4:0] a, output logic [31:0] d);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rdReg

  task automatic regMap;
    rdReg(A_CUST1, rv);
    chk(rv, 32'h2710_0000, "custom reset");
    rdReg(5'h1f, rv);
    chk(rv, 32'h0000_0000, "unmapped read");
    wrReg(A_OFFSET, 32'h0000_1234);
    rdReg(A_OFFSET, rv);
    chk(rv, 32'h0000_0000, "offset read only");
  endtask : regMap

  // filter shift 0 settles within a few 100-cycle updates, so 400 cycles is ample
  task automatic rangeCase(input logic [1:0] code, input logic [15:0] lvl, input logic [15:0] exp);
    wrReg(A_CTRL, {30'h0, code});
    src.set_level(0, lvl);
    waitCyc(400);
    chk({16'h0, refOut[0]}, {16'h0, exp}, "reference one");
  endtask : rangeCase

  task automatic ranges;
    wrReg(A_FILT, 32'h0000_0000);
    rangeCase(2'h0, 16'h1388, 16'h1388);
    rangeCase(2'h1, 16'h1770, 16'h1388);
    rangeCase(2'h2, 16'hec78, 16'hec78);
    wrReg(A_CUST1, 32'h1770_07d0);
    rangeCase(2'h3, 16'h0fa0, 16'h1388);
    wrReg(A_DEAD, 32'h0000_03e8);
    rangeCase(2'h0, 16'h01f4, 16'h0000);
    rangeCase(2'h0, 16'h07d0, 16'h07d0);
    wrReg(A_DEAD, 32'h0000_0000);
  endtask : ranges

  task automatic offsetCmd;
    src.set_level(1, 16'h0bb8);
    waitCyc(400);
    wrReg(A_CMD, 32'h0000_0001);
    rdReg(A_OFFSET, rv);
    chk({16'h0, rv[15:0]}, 32'h0000_0bb8, "offset capture");
    wrReg(A_CMD, 32'h0000_0003);
    rdReg(A_OFFSET, rv);
    chk({16'h0, rv[15:0]}, 32'h0000_0000, "offset clear");
  endtask : offsetCmd

  // input two: reference span 20..40 percent, then offset and sleep on top of it
  task automatic inputTwo;
    wrReg(5'h07, 32'h0fa0_07d0);
    waitCyc(4);
    chk({16'h0, refOut[1]}, 32'h0000_0a28, "scaled reference two");
    wrReg(A_CMD, 32'h0000_0001);
    waitCyc(4);
    chk({16'h0, refOut[1]}, 32'h0000_fe70, "offset reference two");
    wrReg(A_DOEN, 32'h0000_0800);
    wrReg(A_SLEEP, 32'h0000_012c);
    waitCyc(4);
    chk({20'h0, statusOut}, 32'h0000_0800, "sleep below limit");
    wrReg(A_CTRL, 32'h0000_0040);
    waitCyc(4);
    chk({20'h0, statusOut}, 32'h0000_0000, "joystick outside limit");
    wrReg(A_CMD, 32'h0000_0002);
    wrReg(A_CTRL, 32'h0000_0000);
  endtask : inputTwo

  // min of input four equals max of input three; the low half of each span word holds the min
  task automatic targets;
    wrReg(A_TSC3, 32'h03e8_0000);
    wrReg(5'h0c, 32'h07d0_03e8);
    wrReg(A_TID, 32'h025c_025b);
    wrReg(A_FBUS, 32'h09c4_09c4);
    src.set_level(2, 16'h1d4c);
    src.set_level(3, 16'h1d4c);
    wrReg(A_CTRL, 32'h0000_0180);
    waitCyc(400);
    chk({targetValue[1], targetValue[0]}, 32'h04e2_00fa, "fieldbus target");
    chk({targetParameter[1], targetParameter[0]}, 32'h025c_025b, "target id");
    wrReg(A_CTRL, 32'h0000_0380);
    waitCyc(400);
    chk({16'h0, targetValue[0]}, 32'h0000_02ee, "inverted target");
    src.set_level(2, 16'h1388);
    wrReg(A_CTRL, 32'h0000_0100);
    waitCyc(400);
    chk({16'h0, targetValue[0]}, 32'h0000_01f4, "terminal target");
  endtask : targets

  task automatic diMask;
    wrReg(A_INVMASK, 32'h0000_033f);
    @(posedge clock);
    diPin <= 10'h155;
    waitCyc(5);
    chk({22'h0, diFunc}, 32'h0000_026a, "masked inputs");
    wrReg(A_INVMASK, 32'h0000_0000);
    waitCyc(3);
    chk({22'h0, diFunc}, 32'h0000_0155, "unmasked inputs");
  endtask : diMask

  task automatic stat(input logic [11:0] exp);
    waitCyc(4);
    chk({20'h0, statusOut}, {20'h0, exp}, "status");
  endtask : stat

  task automatic status;
    wrReg(A_CTRL, 32'h0000_0000);
    wrReg(A_DOEN, 32'h0000_0fff);
    stat(12'h40b);
    @(posedge clock);
    driveFault <= 1'b1;
    driveWarn <= 1'b1;
    overTemp <= 1'b1;
    stat(12'h497);
    @(posedge clock);
    driveFault <= 1'b0;
    driveWarn <= 1'b0;
    overTemp <= 1'b0;
    outFreq <= 16'hfe0c;
    freqRef <= 16'hfe0c;
    motorSpeed <= 16'hfe0c;
    stat(12'h70b);
    @(posedge clock);
    dirReverse <= 1'b1;
    stat(12'h50b);
    @(posedge clock);
    freqRef <= 16'hfe3e;
    motorSpeed <= 16'hfc7c;
    stat(12'h10b);
    wrReg(A_CTRL, 32'h0000_0800);
    stat(12'h50b);
    @(posedge clock);
    freqRef <= 16'hfed4;
    stat(12'h10b);
    @(posedge clock);
    extFault <= 1'b1;
    for (int r = 0; r < 4; r++) begin
      wrReg(A_CTRL, 32'(r) << 12);
      waitCyc(4);
      chk({31'h0, statusOut[S_EXT]}, {31'h0, r == 1 || r == 3}, "ext indication");
    end
    @(posedge clock);
    extFault <= 1'b0;
    src.set_level(0, 16'h01f4);
    wrReg(A_CTRL, 32'h0000_4001);
    waitCyc(400);
    chk({31'h0, statusOut[S_LOSS]}, 32'h0000_0001, "loss indication");
    wrReg(A_CTRL, 32'h0000_0001);
    waitCyc(4);
    chk({31'h0, statusOut[S_LOSS]}, 32'h0000_0000, "loss silent");
  endtask : status

  initial begin
    #500000;
    nErrors++;
    $display("CHECK FAILED %0t run did not complete", $time);
    endSim;
  end

  initial begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    waitCyc(4);
    chk({20'h0, statusOut}, 32'h0000_0000, "outputs off");
    regMap;
    ranges;
    offsetCmd;
    inputTwo;
    targets;
    diMask;
    status;
    endSim;
  end
endmodule : analog_input_conditioning_bench

// File: sim/analog_source_model.sv
`timescale 1ns/1ns
module analog_source_model (
  output logic [3:0][15:0] termLevel,
  input wire logic clock
);
  // levels change only just after an edge, the way a sampled converter presents them
  logic [3:0][15:0] levelQ = '0;

  assign termLevel = levelQ;

  task automatic set_level(input int ch, input logic [15:0] v);
    @(posedge clock);
    levelQ[ch] <= v;
  endtask : set_level
endmodule : analog_source_model
